// ### scd_host.sv
`default_nettype none
// ====================
// Serial master model.
module scd_host (
    // Serial pins.
    output logic sclk_out,
    output logic cs_b_out,
    output logic din_out,
    input wire logic dout_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] rx;
    initial begin
        sclk_out = 0;
        cs_b_out = 1;
        din_out = 0;
        rx = 0;
    end
    // Clocks n bits MSB first, then leaves a byte gap.
    task automatic xbits(input logic [7:0] tx, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            sclk_out = 1;
            din_out = tx[i];
            #16;
            sclk_out = 0;
            rx = {rx[30:0], dout_in};
            #16;
        end
        #150;
    endtask
    task automatic open_cs;
        cs_b_out = 0;
        #20;
    endtask
    task automatic close_cs;
        #20;
        cs_b_out = 1;
        din_out = ~din_out;
        #600;
    endtask
    task automatic cmd(input logic [7:0] op);
        open_cs();
        xbits(op, 8);
        close_cs();
    endtask
endmodule
`default_nettype wire

// ### scd_link.sv
`default_nettype none
`include "scd_params.svh"
module scd_link
    import scd_pkg::*;
#(
    parameter int SET_W = `SCD_SET_W
) (
    // Reset and serial pins.
    input wire logic rst_b_in,
    input wire logic sclk_in,
    input wire logic cs_b_in,
    input wire logic din_in,
    input wire logic daisy_in_in,
    // Register read data.
    input wire logic [7:0] reg_rdata_in,
    // Serial output.
    output logic dout_out,
    output logic dout_oe_out,
    // Core side.
    scd_link_if.link lk
);
    logic [2:0] fall_cnt;
    logic [6:0] rx;
    logic [7:0] rx_byte;
    logic [1:0] byte_idx;
    logic early_done;
    logic early_hit;
    logic rd_active;
    logic cont_meta, cont_sync, req_meta, req_sync;
    logic [2:0] phase;
    logic [4:0] rise_cnt;
    logic loaded;
    logic fwd;
    logic [SET_W-1:0] tx;
    localparam logic [4:0] REG_LOAD = 5'(`SCD_REG_MSB_EDGE - 1);

    assign rx_byte = {rx, din_in};
    assign early_hit = (byte_idx == `SCD_IDX_FIRST) && (fall_cnt == `SCD_EARLY_EDGE)
        && scd_early_match(rx_byte[6:0]);
    assign fwd = lk.chain_en & daisy_in_in;

    // ==========================================
    // Byte capture on falling edges.
    always_ff @(negedge sclk_in or posedge cs_b_in) begin
        if (cs_b_in) begin
            fall_cnt <= 3'h0;
            rx <= 7'h00;
            byte_idx <= `SCD_IDX_FIRST;
            early_done <= 1'b0;
            rd_active <= 1'b0;
            cont_meta <= 1'b1;
            cont_sync <= 1'b1;
            req_meta <= 1'b0;
            req_sync <= 1'b0;
        end else begin
            cont_meta <= lk.cont_read;
            cont_sync <= cont_meta;
            req_meta <= lk.rdata_req;
            req_sync <= req_meta;
            fall_cnt <= fall_cnt + 3'h1;
            rx <= rx_byte[6:0];
            if (early_hit) begin
                early_done <= 1'b1;
            end
            if (fall_cnt == `SCD_LAST_EDGE) begin
                early_done <= 1'b0;
                if (byte_idx != `SCD_IDX_DATA) begin
                    byte_idx <= byte_idx + 2'h1;
                end
                if (byte_idx == `SCD_IDX_FIRST && scd_tag(rx_byte) == `SCD_TAG_REG_READ
                        && !cont_sync) begin
                    rd_active <= 1'b1;
                end
            end
        end
    end

    // ==========================================
    // Byte events toward the core.
    always_ff @(negedge sclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            lk.evt_toggle <= 1'b0;
            lk.evt_byte <= 8'h00;
            lk.evt_index <= `SCD_IDX_FIRST;
        end else if (early_hit) begin
            lk.evt_toggle <= ~lk.evt_toggle;
            lk.evt_byte <= {rx_byte[6:0], 1'b0};
            lk.evt_index <= byte_idx;
        end else if (fall_cnt == `SCD_LAST_EDGE && !early_done) begin
            lk.evt_toggle <= ~lk.evt_toggle;
            lk.evt_byte <= rx_byte;
            lk.evt_index <= byte_idx;
        end
    end

    // ==========================================
    // Output shifting on rising edges.
    always_ff @(posedge sclk_in or posedge cs_b_in) begin
        if (cs_b_in) begin
            rise_cnt <= 5'h00;
            phase <= 3'h0;
            loaded <= 1'b0;
            tx <= '0;
            dout_out <= 1'b0;
            dout_oe_out <= 1'b0;
        end else begin
            dout_oe_out <= 1'b1;
            phase <= phase + 3'h1;
            if (rise_cnt != REG_LOAD) begin
                rise_cnt <= rise_cnt + 5'h01;
            end
            if (rd_active && rise_cnt == REG_LOAD && phase == 3'h0) begin
                dout_out <= reg_rdata_in[7];
                tx <= {reg_rdata_in[6:0], {(SET_W-7){1'b0}}};
            end else if (!loaded && phase == 3'h0
                    && ((rise_cnt == 5'h00 && lk.data_ready) || req_sync)) begin
                loaded <= 1'b1;
                dout_out <= lk.data_word[SET_W-1];
                tx <= {lk.data_word[SET_W-2:0], fwd};
            end else begin
                dout_out <= tx[SET_W-1];
                tx <= {tx[SET_W-2:0], fwd};
            end
        end
    end
endmodule
`default_nettype wire

// ### scd_link_if.sv
`default_nettype none
`include "scd_params.svh"
interface scd_link_if #(
    parameter int SET_W = `SCD_SET_W
);
    logic evt_toggle;
    logic [7:0] evt_byte;
    logic [1:0] evt_index;
    logic cont_read;
    logic chain_en;
    logic data_ready;
    logic rdata_req;
    logic [SET_W-1:0] data_word;
    modport link (
        output evt_toggle, evt_byte, evt_index,
        input cont_read, chain_en, data_ready, rdata_req, data_word
    );
    modport core (
        input evt_toggle, evt_byte, evt_index,
        output cont_read, chain_en, data_ready, rdata_req, data_word
    );
endinterface
`default_nettype wire

// ### scd_params.svh
// Function
// - Chip select high floats the serial output.
// - Chained forwarding only when chain bit set.
// - Chained mode forwards chain input after own data.
// - Chained mode refuses repeated readback by command.
// - Output and chain input move on rising edges.
// - System and read-once decoded on seventh falling edge.
// - Register opcodes decoded on eighth falling edge.
// - System opcodes 02h, 04h, 06h, 08h, 0Ah.
// - Read opcodes 10h, 11h and 12h.
// - Register opcode bytes carry tag, address, count.
// - Register read ignored during continuous read.
// - Continuous read is the power-up default.
// - Standby holds until the leave-standby opcode.
// - Reset restarts filter, defaults registers, 18 clocks.
// - Start begins conversions, no effect when running.
// - Stop lets current conversion finish, then halts.
// - Register read MSB appears on 17th rising edge.
`ifndef SCD_PARAMS_SVH
`define SCD_PARAMS_SVH
`define SCD_OP_WAKEUP 8'h02
`define SCD_OP_STANDBY 8'h04
`define SCD_OP_RESET 8'h06
`define SCD_OP_START 8'h08
`define SCD_OP_STOP 8'h0a
`define SCD_OP_CONT_READ 8'h10
`define SCD_OP_HALT_READ 8'h11
`define SCD_OP_READ_ONCE 8'h12
`define SCD_TAG_REG_READ 3'h1
`define SCD_TAG_REG_WRITE 3'h2
`define SCD_TAG_COUNT 3'h0
`define SCD_EARLY_EDGE 3'h6
`define SCD_LAST_EDGE 3'h7
`define SCD_REG_MSB_EDGE 17
`define SCD_RESET_TCLK 18
`define SCD_MCLK_PER_TCLK 1
`define SCD_RESET_CYCLES (`SCD_RESET_TCLK * `SCD_MCLK_PER_TCLK)
`define SCD_SET_W 216
`define SCD_IDX_FIRST 2'h0
`define SCD_IDX_SECOND 2'h1
`define SCD_IDX_DATA 2'h2
`endif

// ### scd_pkg.sv
`default_nettype none
`include "scd_params.svh"
package scd_pkg;
    typedef enum logic [2:0] {
        CONV_IDLE = 3'h1,
        CONV_RUN = 3'h2,
        CONV_STOPPING = 3'h4
    } scd_conv_type;
    typedef enum logic [2:0] {
        DEC_IDLE = 3'h1,
        DEC_COUNT = 3'h2,
        DEC_DATA = 3'h4
    } scd_dec_type;
    typedef logic [7:0] scd_byte_type;
    function automatic logic [2:0] scd_tag(input scd_byte_type b);
        scd_tag = b[7:5];
    endfunction
    function automatic logic [6:0] scd_top7(input scd_byte_type b);
        scd_top7 = b[7:1];
    endfunction
    function automatic logic scd_early_match(input logic [6:0] bits);
        scd_early_match = (bits == scd_top7(`SCD_OP_WAKEUP)) || (bits == scd_top7(`SCD_OP_STANDBY))
            || (bits == scd_top7(`SCD_OP_RESET)) || (bits == scd_top7(`SCD_OP_START))
            || (bits == scd_top7(`SCD_OP_STOP)) || (bits == scd_top7(`SCD_OP_READ_ONCE));
    endfunction
endpackage
`default_nettype wire

// ### scd_top.sv
`default_nettype none
`include "scd_params.svh"
module scd_top
    import scd_pkg::*;
#(
    parameter int SET_W = `SCD_SET_W,
    parameter int RESET_CYCLES = `SCD_RESET_CYCLES
) (
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // Serial link.
    input wire logic sclk_in,
    input wire logic cs_b_in,
    input wire logic din_in,
    input wire logic daisy_in_in,
    output logic dout_out,
    output logic dout_oe_out,
    // Configuration.
    input wire logic chain_en_in,
    // Converter datapath.
    input wire logic [SET_W-1:0] result_in,
    input wire logic result_valid_in,
    input wire logic conv_done_in,
    // Register file.
    input wire logic [7:0] reg_rdata_in,
    output logic reg_cmd_valid_out,
    output logic reg_cmd_write_out,
    output logic [4:0] reg_addr_out,
    output logic [4:0] reg_count_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_wstrobe_out,
    // Status.
    output logic standby_out,
    output logic converting_out,
    output logic cont_read_out,
    output logic reset_busy_out
);
    localparam int RST_W = $clog2(RESET_CYCLES + 1);
    localparam logic [RST_W-1:0] RST_LAST = RST_W'(RESET_CYCLES - 1);

    scd_link_if #(.SET_W(SET_W)) lk();

    // ==========================================
    // Serial engine on the link clock.
    scd_link #(
        .SET_W(SET_W)
    ) u_link (
        .rst_b_in(rst_b_in),
        .sclk_in(sclk_in),
        .cs_b_in(cs_b_in),
        .din_in(din_in),
        .daisy_in_in(daisy_in_in),
        .reg_rdata_in(reg_rdata_in),
        .dout_out(dout_out),
        .dout_oe_out(dout_oe_out),
        .lk(lk.link)
    );

    // ==========================================
    // Crossings from the link clock.
    logic cs_meta, cs_sync, cs_last;
    logic tg_meta, tg_sync, tg_last;

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_last <= 1'b1;
            tg_meta <= 1'b0;
            tg_sync <= 1'b0;
            tg_last <= 1'b0;
        end else begin
            cs_meta <= cs_b_in;
            cs_sync <= cs_meta;
            cs_last <= cs_sync;
            tg_meta <= lk.evt_toggle;
            tg_sync <= tg_meta;
            tg_last <= tg_sync;
        end
    end

    // ==========================================
    // Opcode classification.
    logic evt_pulse, is_first, blocked, go, frame_end, link_idle;
    logic [7:0] op;
    logic known_op;

    assign op = lk.evt_byte;
    assign evt_pulse = tg_sync ^ tg_last;
    assign is_first = evt_pulse && (lk.evt_index == `SCD_IDX_FIRST);
    assign blocked = reset_busy_out || (standby_out && op != `SCD_OP_WAKEUP);
    assign go = is_first && !blocked;
    assign frame_end = cs_sync && !cs_last;
    assign link_idle = cs_sync && cs_last;
    assign known_op = (op == `SCD_OP_WAKEUP) || (op == `SCD_OP_STANDBY)
        || (op == `SCD_OP_RESET) || (op == `SCD_OP_START) || (op == `SCD_OP_STOP)
        || (op == `SCD_OP_CONT_READ) || (op == `SCD_OP_HALT_READ)
        || (op == `SCD_OP_READ_ONCE) || (scd_tag(op) == `SCD_TAG_REG_READ)
        || (scd_tag(op) == `SCD_TAG_REG_WRITE);

    // ==========================================
    // Standby control.
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            standby_out <= 1'b0;
        end else if (go && op == `SCD_OP_STANDBY) begin
            standby_out <= 1'b1;
        end else if (go && op == `SCD_OP_WAKEUP) begin
            standby_out <= 1'b0;
        end
    end

    // ==========================================
    // Reset sequencing.
    logic [RST_W-1:0] rst_cnt;

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            reset_busy_out <= 1'b0;
            rst_cnt <= '0;
        end else if (go && op == `SCD_OP_RESET) begin
            reset_busy_out <= 1'b1;
            rst_cnt <= '0;
        end else if (reset_busy_out) begin
            rst_cnt <= rst_cnt + RST_W'(1);
            if (rst_cnt == RST_LAST) begin
                reset_busy_out <= 1'b0;
            end
        end
    end

    // ==========================================
    // Continuous read mode.
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            cont_read_out <= 1'b1;
        end else if (go && op == `SCD_OP_CONT_READ) begin
            cont_read_out <= 1'b1;
        end else if (go && op == `SCD_OP_HALT_READ) begin
            cont_read_out <= 1'b0;
        end
    end

    assign lk.cont_read = cont_read_out;
    assign lk.chain_en = chain_en_in;

    // ==========================================
    // Conversion control.
    scd_conv_type conv;

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            conv <= CONV_IDLE;
            converting_out <= 1'b0;
        end else begin
            case (conv)
                CONV_IDLE: begin
                    if (go && op == `SCD_OP_START) begin
                        conv <= CONV_RUN;
                        converting_out <= 1'b1;
                    end
                end
                CONV_RUN: begin
                    if (go && op == `SCD_OP_STOP) begin
                        conv <= CONV_STOPPING;
                    end
                end
                CONV_STOPPING: begin
                    if (go && op == `SCD_OP_START) begin
                        conv <= CONV_RUN;
                    end else if (conv_done_in) begin
                        conv <= CONV_IDLE;
                        converting_out <= 1'b0;
                    end
                end
                default: begin
                    conv <= CONV_IDLE;
                    converting_out <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================
    // Register command decoding.
    scd_dec_type dec;
    logic [4:0] remaining;
    logic data_seen;

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            dec <= DEC_IDLE;
            remaining <= 5'h00;
            data_seen <= 1'b0;
            reg_cmd_valid_out <= 1'b0;
            reg_cmd_write_out <= 1'b0;
            reg_addr_out <= 5'h00;
            reg_count_out <= 5'h00;
            reg_wdata_out <= 8'h00;
            reg_wstrobe_out <= 1'b0;
        end else begin
            reg_cmd_valid_out <= 1'b0;
            reg_wstrobe_out <= 1'b0;
            if (frame_end || reset_busy_out) begin
                dec <= DEC_IDLE;
            end else if (go) begin
                dec <= DEC_IDLE;
                if (scd_tag(op) == `SCD_TAG_REG_READ && !cont_read_out) begin
                    dec <= DEC_COUNT;
                    reg_cmd_write_out <= 1'b0;
                    reg_addr_out <= op[4:0];
                end else if (scd_tag(op) == `SCD_TAG_REG_WRITE) begin
                    dec <= DEC_COUNT;
                    reg_cmd_write_out <= 1'b1;
                    reg_addr_out <= op[4:0];
                end
            end else if (evt_pulse) begin
                case (dec)
                    DEC_COUNT: begin
                        if (lk.evt_index == `SCD_IDX_SECOND
                                && scd_tag(op) == `SCD_TAG_COUNT) begin
                            dec <= DEC_DATA;
                            reg_count_out <= op[4:0];
                            remaining <= op[4:0];
                            data_seen <= 1'b0;
                            reg_cmd_valid_out <= 1'b1;
                        end else begin
                            dec <= DEC_IDLE;
                        end
                    end
                    DEC_DATA: begin
                        data_seen <= 1'b1;
                        remaining <= remaining - 5'h01;
                        if (remaining == 5'h00) begin
                            dec <= DEC_IDLE;
                        end
                        if (reg_cmd_write_out) begin
                            reg_wdata_out <= op;
                            reg_wstrobe_out <= 1'b1;
                            if (data_seen) begin
                                reg_addr_out <= reg_addr_out + 5'h01;
                            end
                        end else begin
                            reg_addr_out <= reg_addr_out + 5'h01;
                        end
                    end
                    default: begin
                        dec <= DEC_IDLE;
                    end
                endcase
            end
        end
    end

    // ==========================================
    // Conversion data handed to the link.
    logic [SET_W-1:0] data_word;
    logic fresh, have_result, read_once_used, rdata_req, data_ready, capture;

    assign capture = result_valid_in && link_idle;

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            data_word <= '0;
            fresh <= 1'b0;
            have_result <= 1'b0;
        end else if (capture) begin
            data_word <= result_in;
            fresh <= 1'b1;
            have_result <= 1'b1;
        end else if (frame_end && data_ready) begin
            fresh <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            data_ready <= 1'b0;
        end else if (link_idle) begin
            data_ready <= cont_read_out && fresh && !capture && !standby_out;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            rdata_req <= 1'b0;
            read_once_used <= 1'b0;
        end else begin
            if (frame_end) begin
                rdata_req <= 1'b0;
            end else if (go && op == `SCD_OP_READ_ONCE && !cont_read_out && have_result
                    && !(chain_en_in && read_once_used)) begin
                rdata_req <= 1'b1;
            end
            if (capture) begin
                read_once_used <= 1'b0;
            end else if (frame_end && rdata_req) begin
                read_once_used <= 1'b1;
            end
        end
    end

    assign lk.data_word = data_word;
    assign lk.data_ready = data_ready;
    assign lk.rdata_req = rdata_req;

    // ==========================================
    // Checks.
    logic [RST_W:0] busy_len;

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            busy_len <= '0;
        end else if (reset_busy_out) begin
            busy_len <= busy_len + (RST_W+1)'(1);
        end else begin
            busy_len <= '0;
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    property p_hiz;
        cs_b_in |-> !dout_oe_out;
    endproperty
    a_hiz: assert property (p_hiz) else $error("output driven while deselected");

    property p_standby_enter;
        go && op == `SCD_OP_STANDBY |=> standby_out ##1 standby_out;
    endproperty
    a_standby_enter: assert property (p_standby_enter) else $error("standby not entered");

    property p_standby_hold;
        standby_out && !(is_first && op == `SCD_OP_WAKEUP && !reset_busy_out) |=> standby_out;
    endproperty
    a_standby_hold: assert property (p_standby_hold) else $error("standby left early");

    property p_reset_len;
        $fell(reset_busy_out) |-> busy_len == (RST_W+1)'(RESET_CYCLES);
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("reset length wrong");

    property p_cont_default;
        $rose(rst_b_in) |-> cont_read_out;
    endproperty
    a_cont_default: assert property (p_cont_default) else $error("not in continuous read");

    property p_halt;
        go && op == `SCD_OP_HALT_READ |=> !cont_read_out;
    endproperty
    a_halt: assert property (p_halt) else $error("continuous read not halted");

    property p_start_noeff;
        go && op == `SCD_OP_START && conv == CONV_RUN |=> conv == CONV_RUN && converting_out;
    endproperty
    a_start_noeff: assert property (p_start_noeff) else $error("start disturbed run");

    property p_stop_wait;
        conv == CONV_STOPPING && !conv_done_in |=> converting_out;
    endproperty
    a_stop_wait: assert property (p_stop_wait) else $error("stopped before done");

    property p_register_read_cmd_ignored;
        is_first && scd_tag(op) == `SCD_TAG_REG_READ && cont_read_out |=> dec == DEC_IDLE;
    endproperty
    a_register_read_cmd_ignored: assert property (p_register_read_cmd_ignored) else $error("register read taken");

    property p_unknown;
        is_first && !known_op |=> $stable(standby_out) && $stable(cont_read_out)
            && $stable(reset_busy_out) && dec == DEC_IDLE;
    endproperty
    a_unknown: assert property (p_unknown) else $error("unknown opcode acted on");

    property p_chain_reread;
        go && op == `SCD_OP_READ_ONCE && chain_en_in && read_once_used && !rdata_req
            |=> !rdata_req;
    endproperty
    a_chain_reread: assert property (p_chain_reread) else $error("chained reread allowed");

    property p_count;
        evt_pulse && !is_first && dec == DEC_COUNT && scd_tag(op) == `SCD_TAG_COUNT
            && !frame_end && !reset_busy_out
            |=> reg_cmd_valid_out && reg_count_out == $past(op[4:0]) ##1 !reg_cmd_valid_out;
    endproperty
    a_count: assert property (p_count) else $error("count byte mishandled");

    c_reset: cover property (go && op == `SCD_OP_RESET ##1 reset_busy_out);
    c_wake: cover property (standby_out ##[1:200] !standby_out);
    c_write: cover property (reg_cmd_valid_out && reg_cmd_write_out ##[1:500] reg_wstrobe_out);
    c_stop: cover property (conv == CONV_STOPPING ##[1:200] conv == CONV_IDLE);
endmodule
`default_nettype wire

// ### tb_serial_command_decoder_chain.sv
`default_nettype none
// ====================
// Bench top.
module tb_serial_command_decoder_chain;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst_b, chain_en, rv, done, sclk, cs_b, din, daisy, dout, oe;
    logic cv, wr, ws, sb, cnv, cr, rbusy;
    logic [15:0] res, seen;
    logic [4:0] addr, cnt;
    logic [7:0] wd, rdat;
    int n_errors = 0;
    int checks = 0;
    scd_host host_u (.sclk_out(sclk), .cs_b_out(cs_b), .din_out(din), .dout_in(dout));
    scd_top #(.SET_W(16), .RESET_CYCLES(18)) dut_u (.mclk_in(mclk), .rst_b_in(rst_b),
        .sclk_in(sclk), .cs_b_in(cs_b), .din_in(din), .daisy_in_in(daisy), .dout_out(dout),
        .dout_oe_out(oe), .chain_en_in(chain_en), .result_in(res), .result_valid_in(rv),
        .conv_done_in(done), .reg_rdata_in(rdat), .reg_cmd_valid_out(cv),
        .reg_cmd_write_out(wr), .reg_addr_out(addr), .reg_count_out(cnt), .reg_wdata_out(wd),
        .reg_wstrobe_out(ws), .standby_out(sb), .converting_out(cnv), .cont_read_out(cr),
        .reset_busy_out(rbusy));
    // Register file model: each register holds 0xa0 plus its address.
    assign rdat = {3'h5, addr};
    initial begin
        mclk = 0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (cv) seen[15:8] <= {1'b1, wr, 1'b0, addr};
        if (ws) seen[7:0] <= wd;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic t_read(input logic [15:0] d, input logic ch);
        @(negedge mclk) chain_en = ch;
        daisy = ch;
        res = d;
        rv = 1;
        @(negedge mclk) rv = 0;
        #200;
        host_u.open_cs();
        host_u.xbits(8'h00, 8);
        host_u.xbits(8'h00, 8);
        host_u.xbits(8'h00, 1);
        host_u.xbits(8'h00, 8);
        chk("oe", 1, oe);
        host_u.close_cs();
        chk("oe", 0, oe);
        chk("data", d, host_u.rx[24:9]);
        chk("fill", ch ? 9'h1ff : 9'h000, host_u.rx[8:0]);
    endtask
    task automatic t_mode;
        host_u.cmd(8'hff);
        chk("state", 3'b001, {sb, cnv, cr});
        host_u.open_cs();
        host_u.xbits(8'h23, 8);
        host_u.xbits(8'h00, 8);
        host_u.close_cs();
        chk("register_read_cmd", 0, seen);
        host_u.cmd(8'h11);
        chk("cont", 0, cr);
        host_u.open_cs();
        host_u.xbits(8'h43, 8);
        host_u.xbits(8'h00, 8);
        host_u.xbits(8'ha5, 8);
        host_u.close_cs();
        chk("register_write_cmd", 16'hc3a5, seen);
        t_register_read_cmd();
        t_once();
        host_u.cmd(8'h10);
        chk("cont", 1, cr);
    endtask
    task automatic t_register_read_cmd;
        host_u.open_cs();
        host_u.xbits(8'h25, 8);
        host_u.xbits(8'h01, 8);
        host_u.xbits(8'h00, 8);
        host_u.xbits(8'h00, 8);
        host_u.close_cs();
        chk("rdata", 16'ha5a6, host_u.rx[15:0]);
        chk("rcmd", 16'h85a5, seen);
        chk("count", 16'h0001, {11'h000, cnt});
    endtask
    task automatic t_once;
        @(negedge mclk) chain_en = 1;
        daisy = 0;
        res = 16'h9c63;
        rv = 1;
        @(negedge mclk) rv = 0;
        for (int k = 0; k < 2; k++) begin
            host_u.open_cs();
            host_u.xbits(8'h12, 8);
            host_u.xbits(8'h00, 8);
            host_u.xbits(8'h00, 8);
            host_u.xbits(8'h00, 8);
            host_u.close_cs();
            chk("once", (k == 0) ? 16'h9c63 : 16'h0000, host_u.rx[15:0]);
        end
        @(negedge mclk) chain_en = 0;
    endtask
    task automatic t_standby;
        host_u.cmd(8'h04);
        chk("standby", 1, sb);
        host_u.cmd(8'h08);
        chk("conv", 0, cnv);
        host_u.cmd(8'h02);
        chk("standby", 0, sb);
    endtask
    task automatic t_conv;
        host_u.cmd(8'h08);
        chk("conv", 1, cnv);
        host_u.cmd(8'h0a);
        chk("conv", 1, cnv);
        @(negedge mclk) done = 1;
        @(negedge mclk) done = 0;
        repeat (6) @(negedge mclk);
        chk("conv", 0, cnv);
    endtask
    task automatic t_reset;
        host_u.open_cs();
        host_u.xbits(8'h06, 8);
        chk("busy", 1, rbusy);
        host_u.close_cs();
        chk("busy", 0, rbusy);
    endtask
    initial begin
        #300000;
        n_errors++;
        end_of_test();
    end
    initial begin
        {rst_b, chain_en, rv, done, daisy, res, seen} = 0;
        repeat (8) @(negedge mclk);
        rst_b = 1;
        repeat (4) @(negedge mclk);
        chk("cont", 1, cr);
        t_read(16'hc35a, 0);
        t_read(16'h5aa5, 1);
        t_read(16'h0ff0, 0);
        t_mode();
        t_standby();
        t_conv();
        t_reset();
        end_of_test();
    end
endmodule
`default_nettype wire
